/* File: design/isc_top.sv */
// Configuration and routing for interrupt sources 48 and 49.
// Assumes one 125 MHz clock, async active-high reset, and a strobe register port
// whose read data is expected one cycle after the read strobe.
//
// Operation
// - Source 49 sense: 01 detects high level, 11 rising edge; 00, 10 prohibited.
// - Source 48 sense supports only rising edge 11; other codes prohibited.
// - Source 49 DMA-trigger bit set routes its interrupt as DMA trigger.
// - Source 48 DMA-trigger bit set routes its interrupt as DMA trigger.
// - Trigger bit clear: three-bit field is priority, 000 disables, 1-7 levels.
// - Trigger bit set: three-bit field selects DMA channel zero to seven.
// - All sense, trigger and level fields reset to zero.
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module isc_top #(
  parameter int LEVEL_BITS = isc_pkg::LEVEL_W,
  parameter int DMA_CHANNELS = isc_pkg::NUM_DMA_CH
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // Register port
  input wire logic [isc_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [isc_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WE_I,
  input wire logic RE_I,
  output logic [isc_pkg::DATA_W-1:0] RDATA_O,
  // Interrupt source pins, source 48 in bit 0
  input wire logic [isc_pkg::NUM_SRC-1:0] SRC_PIN_I,
  // Requests to the processor core
  output isc_pkg::core_req_t CORE_REQ48_O,
  output isc_pkg::core_req_t CORE_REQ49_O,
  // Triggers to the DMA controller, one bit per channel
  output logic [isc_pkg::NUM_DMA_CH-1:0] DMA_TRIG_O,
  // Block interrupt
  output logic IRQ_O
);
  import isc_pkg::*;

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  generate
    if (LEVEL_BITS != LEVEL_W) begin : g_bad_level
      $error("level field width must be three bits");
    end
    if (DMA_CHANNELS != (1 << LEVEL_W)) begin : g_bad_dma
      $error("DMA channel count must match the three-bit channel field");
    end
  endgenerate

  // ==========================================================================
  // Declarations
  // ==========================================================================
  src_cfg_t cfg [NUM_SRC];
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic [NUM_SRC-1:0] pin_sync;
  logic [NUM_SRC-1:0] sense_ok;
  logic [NUM_SRC-1:0] detect;
  logic [NUM_SRC-1:0] core_hit;
  logic [NUM_SRC-1:0] bad_write;
  logic [NUM_DMA_CH-1:0] next_dma_trig;
  logic [DATA_W-1:0] next_rdata;
  logic [ST_W-1:0] events;
  logic [ST_W-1:0] next_status;
  logic [15:0] cfg_word;
  logic wr_cfg;
  logic wr_status;
  logic wr_mask;

  // ==========================================================================
  // Register port decode
  // ==========================================================================
  // Write strobes per register; writes to other offsets are dropped
  assign wr_cfg = WE_I && (ADDR_I == OFS_CFG);
  assign wr_status = WE_I && (ADDR_I == OFS_STATUS);
  assign wr_mask = WE_I && (ADDR_I == OFS_MASK);

  // ==========================================================================
  // Per-source configuration, detection and routing
  // ==========================================================================
  generate
    for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
      localparam int LSB = s * CFG_BYTE_W;
      // Only source 49 may sense a high level
      localparam bit LEVEL_OK = (s == 1);
      src_cfg_t wcfg;

      // Field image of the byte being written for this source
      assign wcfg.sense = WDATA_I[LSB+CFG_SENSE_LSB +: SENSE_W];
      assign wcfg.dma_en = WDATA_I[LSB+CFG_DMA_BIT];
      assign wcfg.level = WDATA_I[LSB+CFG_LEVEL_LSB +: LEVEL_W];

      // Configuration fields clear on reset, software loads them
      always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
          cfg[s] <= src_cfg_t'(CFG_RST[LSB +: 6]);
        end else if (wr_cfg) begin
          cfg[s] <= wcfg;
        end
      end

      // A write of a prohibited nonzero sense code is flagged
      always_comb begin
        bad_write[s] = 1'b0;
        if (wr_cfg && (wcfg.sense != SENSE_OFF)) begin
          if (wcfg.sense == SENSE_RISING) begin
            bad_write[s] = 1'b0;
          end else if (LEVEL_OK && (wcfg.sense == SENSE_HIGH_LEVEL)) begin
            bad_write[s] = 1'b0;
          end else begin
            bad_write[s] = 1'b1;
          end
        end
      end

      // Synchronise the pin and apply the programmed active condition
      isc_sense_detect #(
        .ALLOW_LEVEL(LEVEL_OK)
      ) u_detect (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .pin_i(SRC_PIN_I[s]),
        .sense_i(cfg[s].sense),
        .pin_sync_o(pin_sync[s]),
        .sense_ok_o(sense_ok[s]),
        .detect_o(detect[s])
      );

      // Core path needs trigger off and a nonzero priority
      assign core_hit[s] = detect[s] && !cfg[s].dma_en && (cfg[s].level != LEVEL_DISABLED);
    end
  endgenerate

  // ==========================================================================
  // Core requests
  // ==========================================================================
  // Source 48 request with its priority level
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      CORE_REQ48_O <= '0;
    end else begin
      CORE_REQ48_O.req <= core_hit[0];
      CORE_REQ48_O.level <= core_hit[0] ? cfg[0].level : LEVEL_DISABLED;
    end
  end

  // Source 49 request with its priority level
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      CORE_REQ49_O <= '0;
    end else begin
      CORE_REQ49_O.req <= core_hit[1];
      CORE_REQ49_O.level <= core_hit[1] ? cfg[1].level : LEVEL_DISABLED;
    end
  end

  // ==========================================================================
  // DMA triggers
  // ==========================================================================
  // Each source with its trigger bit set strikes the channel its field names
  always_comb begin
    next_dma_trig = '0;
    if (detect[0] && cfg[0].dma_en) begin
      next_dma_trig[cfg[0].level] = 1'b1;
    end
    if (detect[1] && cfg[1].dma_en) begin
      next_dma_trig[cfg[1].level] = 1'b1;
    end
  end

  // Registered trigger vector; a cleared trigger bit never reaches it
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      DMA_TRIG_O <= '0;
    end else begin
      DMA_TRIG_O <= next_dma_trig;
    end
  end

  // ==========================================================================
  // Event status, mask and block interrupt
  // ==========================================================================
  // Detections and prohibited-code writes are the block's events
  assign events = {bad_write, detect};

  // New events win over a write-one clear in the same cycle
  always_comb begin
    next_status = status;
    if (wr_status) begin
      next_status = status & ~WDATA_I[ST_W-1:0];
    end
    next_status = next_status | events;
  end

  // Sticky status bits
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      status <= STATUS_RST;
    end else begin
      status <= next_status;
    end
  end

  // Mask register, one enable per status bit
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      mask <= MASK_RST;
    end else if (wr_mask) begin
      mask <= WDATA_I[ST_W-1:0];
    end
  end

  // Level interrupt while any unmasked status bit stands
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(next_status & mask);
    end
  end

  // ==========================================================================
  // Read-back
  // ==========================================================================
  // Both configuration bytes in their documented bit places
  always_comb begin
    cfg_word = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      cfg_word[s*CFG_BYTE_W+CFG_SENSE_LSB +: SENSE_W] = cfg[s].sense;
      cfg_word[s*CFG_BYTE_W+CFG_DMA_BIT] = cfg[s].dma_en;
      cfg_word[s*CFG_BYTE_W+CFG_LEVEL_LSB +: LEVEL_W] = cfg[s].level;
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    next_rdata = '0;
    case (ADDR_I)
      OFS_CFG: begin
        next_rdata[15:0] = cfg_word;
      end
      OFS_STATUS: begin
        next_rdata[ST_W-1:0] = status;
      end
      OFS_MASK: begin
        next_rdata[ST_W-1:0] = mask;
      end
      OFS_STATE: begin
        next_rdata[STATE_PIN_LSB +: NUM_SRC] = pin_sync;
        next_rdata[STATE_REQ_LSB +: NUM_SRC] = core_hit;
        next_rdata[STATE_OK_LSB +: NUM_SRC] = sense_ok;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // Read data stand for exactly the cycle after the strobe
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      RDATA_O <= '0;
    end else if (RE_I) begin
      RDATA_O <= next_rdata;
    end else begin
      RDATA_O <= '0;
    end
  end

endmodule : isc_top

`default_nettype wire

/* File: inc/isc_pkg.sv */
// Shared constants and types for the two-source interrupt configuration block.
// Assumes a single 125 MHz clock domain and a simple strobe-based register port.
package isc_pkg;

  // ==========================================================================
  // Geometry
  // ==========================================================================
  localparam int NUM_SRC = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LEVEL_W = 3;
  localparam int SENSE_W = 2;
  localparam int NUM_DMA_CH = 8;
  localparam int SYNC_STAGES = 2;

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [ADDR_W-1:0] OFS_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATE = 8'h0c;

  // ==========================================================================
  // Configuration field layout: one byte per source, source 48 in byte 0
  // ==========================================================================
  localparam int CFG_BYTE_W = 8;
  localparam int CFG_LEVEL_LSB = 0;
  localparam int CFG_DMA_BIT = 3;
  localparam int CFG_SENSE_LSB = 4;
  localparam logic [15:0] CFG_RST = 16'h0000;

  // ==========================================================================
  // Status and mask layout
  // ==========================================================================
  localparam int ST_DET_LSB = 0;
  localparam int ST_BAD_LSB = 2;
  localparam int ST_W = 4;
  localparam logic [ST_W-1:0] STATUS_RST = 4'h0;
  localparam logic [ST_W-1:0] MASK_RST = 4'h0;

  // ==========================================================================
  // State register layout
  // ==========================================================================
  localparam int STATE_PIN_LSB = 0;
  localparam int STATE_REQ_LSB = 2;
  localparam int STATE_OK_LSB = 4;

  // ==========================================================================
  // Encodings
  // ==========================================================================
  localparam logic [SENSE_W-1:0] SENSE_OFF = 2'h0;
  localparam logic [SENSE_W-1:0] SENSE_HIGH_LEVEL = 2'h1;
  localparam logic [SENSE_W-1:0] SENSE_RISING = 2'h3;
  localparam logic [LEVEL_W-1:0] LEVEL_DISABLED = 3'h0;

  // Per-source configuration as software programs it
  typedef struct packed {
    logic [SENSE_W-1:0] sense;
    logic dma_en;
    logic [LEVEL_W-1:0] level;
  } src_cfg_t;

  // Request presented to the processor core
  typedef struct packed {
    logic req;
    logic [LEVEL_W-1:0] level;
  } core_req_t;

endpackage : isc_pkg

/* File: design/isc_sense_detect.sv */
// Per-source input synchroniser and active-condition detector.
// Assumes the pin is asynchronous to clk_i; sense code comes from the same clock.
`timescale 1ns/1ps
`default_nettype none

module isc_sense_detect #(
  parameter bit ALLOW_LEVEL = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pin and configuration
  input wire logic pin_i,
  input wire logic [isc_pkg::SENSE_W-1:0] sense_i,
  // Results
  output logic pin_sync_o,
  output logic sense_ok_o,
  output logic detect_o
);
  import isc_pkg::*;

  logic [SYNC_STAGES-1:0] sync;
  logic pin_prev;

  // ==========================================================================
  // Two-flop synchroniser, then a history flop for edge detection
  // ==========================================================================
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync <= '0;
      pin_prev <= 1'b0;
    end else begin
      sync <= {sync[SYNC_STAGES-2:0], pin_i};
      pin_prev <= sync[SYNC_STAGES-1];
    end
  end

  assign pin_sync_o = sync[SYNC_STAGES-1];

  // Prohibited codes detect nothing
  always_comb begin
    sense_ok_o = 1'b0;
    detect_o = 1'b0;
    case (sense_i)
      SENSE_HIGH_LEVEL: begin
        sense_ok_o = ALLOW_LEVEL;
        detect_o = ALLOW_LEVEL & sync[SYNC_STAGES-1];
      end
      SENSE_RISING: begin
        sense_ok_o = 1'b1;
        detect_o = sync[SYNC_STAGES-1] & ~pin_prev;
      end
      default: begin
        sense_ok_o = 1'b0;
        detect_o = 1'b0;
      end
    endcase
  end

endmodule : isc_sense_detect

`default_nettype wire

/* File: verif/isc_top_checker.sv */
// Concurrent checks on the ports of isc_top, bound into every instance.
// Assumes the configuration word changes only through the register port.
`timescale 1ns/1ps
`default_nettype none

module isc_top_checker (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // Register port
  input wire logic [isc_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [isc_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WE_I,
  input wire logic RE_I,
  input wire logic [isc_pkg::DATA_W-1:0] RDATA_O,
  // Pins and outputs
  input wire logic [isc_pkg::NUM_SRC-1:0] SRC_PIN_I,
  input wire isc_pkg::core_req_t CORE_REQ48_O,
  input wire isc_pkg::core_req_t CORE_REQ49_O,
  input wire logic [isc_pkg::NUM_DMA_CH-1:0] DMA_TRIG_O
);
  import isc_pkg::*;

  // ==========================================================================
  // Shadow of the configuration word
  // ==========================================================================
  logic [15:0] cfg;
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) cfg <= 16'h0000;
    else if (WE_I && ADDR_I == OFS_CFG) cfg <= WDATA_I[15:0];
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  // ==========================================================================
  // Properties
  // ==========================================================================
  chk_rdata_idle: assert property (!$past(RE_I) |-> RDATA_O == 32'h0)
    else $error("read data not zero outside a read");
  chk_cfg_readback: assert property ($past(RE_I) && $past(ADDR_I) == OFS_CFG
    |-> RDATA_O == {16'h0000, $past(cfg)})
    else $error("configuration read back wrong");
  chk_req48_cause: assert property (CORE_REQ48_O.req |-> cfg[5:4] == SENSE_RISING
    && !cfg[3] && cfg[2:0] != 3'h0 && CORE_REQ48_O.level == cfg[2:0])
    else $error("source 48 request without its settings");
  chk_req49_cause: assert property (CORE_REQ49_O.req |-> cfg[12] && !cfg[11]
    && cfg[10:8] != 3'h0 && CORE_REQ49_O.level == cfg[10:8])
    else $error("source 49 request without its settings");
  chk_dma_route: assert property ((DMA_TRIG_O & ~((8'(cfg[3]) << cfg[2:0])
    | (8'(cfg[11]) << cfg[10:8]))) == 8'h0)
    else $error("trigger on a channel not selected");
  chk_edge_pulse: assert property (CORE_REQ48_O.req |=> !CORE_REQ48_O.req)
    else $error("edge request longer than one cycle");
  chk_pin_latency: assert property ($rose(SRC_PIN_I[0]) && cfg[5:4] == SENSE_RISING
    && !cfg[3] && cfg[2:0] != 3'h0 |-> ##[2:3] CORE_REQ48_O.req)
    else $error("source 48 edge not requested in time");
  chk_dma_latency: assert property ($rose(SRC_PIN_I[1]) && cfg[13:12] == SENSE_RISING
    && cfg[11] |-> ##[2:3] DMA_TRIG_O[cfg[10:8]])
    else $error("source 49 trigger not raised in time");
  chk_level_hold: assert property ((SRC_PIN_I[1] && cfg[13:12] == SENSE_HIGH_LEVEL
    && !cfg[11] && cfg[10:8] != 3'h0) [*4] |-> CORE_REQ49_O.req)
    else $error("level request dropped while pin high");
endmodule : isc_top_checker

bind isc_top isc_top_checker i_chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WE_I(WE_I), .RE_I(RE_I), .RDATA_O(RDATA_O),
  .SRC_PIN_I(SRC_PIN_I), .CORE_REQ48_O(CORE_REQ48_O),
  .CORE_REQ49_O(CORE_REQ49_O), .DMA_TRIG_O(DMA_TRIG_O));

`default_nettype wire

/* File: verif/isc_far_model.sv */
// Stand-in for the processor core and the DMA controller.
// Assumes requests and triggers arrive as registered outputs of isc_top.
`timescale 1ns/1ps
`default_nettype none

module isc_far_model (
  // Clock, reset and counter clear
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  // Requests and triggers
  input wire isc_pkg::core_req_t req48_i,
  input wire isc_pkg::core_req_t req49_i,
  input wire logic [isc_pkg::NUM_DMA_CH-1:0] dma_i,
  // Observations
  output logic [7:0] hits48_o,
  output logic [7:0] hits49_o,
  output logic [2:0] lvl_o,
  output logic [isc_pkg::NUM_DMA_CH-1:0] seen_o
);
  import isc_pkg::*;

  // Core accepts every request cycle and keeps its priority
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i || clr_i) begin
      hits48_o <= 8'h00;
      hits49_o <= 8'h00;
      lvl_o <= 3'h0;
    end else begin
      hits48_o <= hits48_o + 8'(req48_i.req);
      hits49_o <= hits49_o + 8'(req49_i.req);
      if (req48_i.req) lvl_o <= req48_i.level;
      if (req49_i.req) lvl_o <= req49_i.level;
    end
  end

  // DMA controller gathers every channel triggered
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i || clr_i) seen_o <= 8'h00;
    else seen_o <= seen_o | dma_i;
  end
endmodule : isc_far_model

`default_nettype wire

/* File: verif/isc_top_tb.sv */
// Self-checking bench for isc_top with a core and DMA stand-in.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %s exp %0h seen %0h", n, e, a); end end

module isc_top_tb;
  import isc_pkg::*;
  logic clk, rst, we, re, clr;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [1:0] pin;
  core_req_t req48, req49;
  logic [7:0] trig, hits48, hits49, seen;
  logic [2:0] lvl;
  logic irq;
  int tests_run = 0;
  int miscompares = 0;

  // Design, far side and clock
  isc_top i_dut (.CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WE_I(we), .RE_I(re), .RDATA_O(rdata), .SRC_PIN_I(pin), .CORE_REQ48_O(req48),
    .CORE_REQ49_O(req49), .DMA_TRIG_O(trig), .IRQ_O(irq));
  isc_far_model i_far (.clk_i(clk), .rst_i(rst), .clr_i(clr), .req48_i(req48),
    .req49_i(req49), .dma_i(trig), .hits48_o(hits48), .hits49_o(hits49),
    .lvl_o(lvl), .seen_o(seen));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================================
  // Bus and pin tasks
  // ==========================================================================
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // Pin high for n cycles, far side cleared at the rise
  task automatic pulse(input int s, input int n);
    @(posedge clk);
    clr <= 1'b1;
    pin[s] <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n - 1) @(posedge clk);
    pin[s] <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask : pulse

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    logic [31:0] d;
    for (int a = 0; a < 20; a += 4) begin
      rd(8'(a), d);
      `CHK("reset value", 32'h0, d)
    end
    `CHK("irq idle", 1'b0, irq)
  endtask : t_reset

  task automatic t_prio();
    for (int l = 0; l < 8; l++) begin
      wr(OFS_CFG, 32'h30 | l);
      pulse(0, 2);
      `CHK("req48 count", (l == 0) ? 8'h0 : 8'h1, hits48)
      if (l != 0) `CHK("req48 level", 3'(l), lvl)
      `CHK("no dma", 8'h0, seen)
    end
  endtask : t_prio

  task automatic t_dma();
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 8; c++) begin
        wr(OFS_CFG, (32'h38 | c) << (8 * s));
        pulse(s, 2);
        `CHK("dma channel", 8'h1 << c, seen)
        `CHK("no core req", 8'h0, hits48 | hits49)
      end
  endtask : t_dma

  task automatic t_sense();
    logic [3:0] bad [5] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'ha};
    foreach (bad[i]) begin
      wr(OFS_CFG, 32'({2'h0, bad[i][1:0], 4'h7}) << (8 * bad[i][3]));
      pulse(bad[i][3], 2);
      `CHK("prohibited code", 8'h0, hits48 | hits49)
    end
    wr(OFS_CFG, 32'h1500); // Wake-up use takes high level
    pulse(1, 8);
    `CHK("level hold", 8'h8, hits49)
    `CHK("level prio", 3'h5, lvl)
    wr(OFS_CFG, 32'h3500);
    pulse(1, 8);
    `CHK("edge once", 8'h1, hits49)
  endtask : t_sense

  task automatic t_irq();
    logic [31:0] d;
    // Earlier scenarios leave sticky bits behind; start from a clean status
    wr(OFS_STATUS, 32'hf);
    wr(OFS_MASK, 32'h1);
    wr(OFS_CFG, 32'h31);
    pulse(0, 2);
    `CHK("irq raised", 1'b1, irq)
    rd(OFS_STATUS, d);
    `CHK("status set", 32'h1, d)
    wr(OFS_STATUS, 32'h1);
    @(posedge clk);
    #1;
    `CHK("irq cleared", 1'b0, irq)
    wr(OFS_MASK, 32'h0);
    pulse(0, 2);
    `CHK("irq masked", 1'b0, irq)
    rd(OFS_STATUS, d);
    `CHK("status masked", 32'h1, d)
  endtask : t_irq

  // ==========================================================================
  // Verdict, watchdog and main sequence
  // ==========================================================================
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    we = 1'b0;
    re = 1'b0;
    clr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    pin = 2'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_prio();
    t_dma();
    t_sense();
    t_irq();
    print_verdict();
  end
endmodule : isc_top_tb

`default_nettype wire
